// ### pkg/busr_map.vh
// constants for the four-bit universal shift register and its command queue
`ifndef BUSR_MAP_VH
`define BUSR_MAP_VH

// register width and reset value
`define BUSR_WIDTH        4
`define BUSR_RESET_VALUE  4'h0

// mode_select codes, bit 1 is the upper select, bit 0 the lower
`define BUSR_MODE_HOLD    2'h0
`define BUSR_MODE_RIGHT   2'h1
`define BUSR_MODE_LEFT    2'h2
`define BUSR_MODE_LOAD    2'h3

// command word layout
`define BUSR_CMD_WIDTH    8
`define BUSR_CMD_DATA_LSB 0
`define BUSR_CMD_DATA_MSB 3
`define BUSR_CMD_LEFT_BIT 4
`define BUSR_CMD_RIGHT_BIT 5
`define BUSR_CMD_MODE_LSB 6
`define BUSR_CMD_MODE_MSB 7

// command queue depth
`define BUSR_QUEUE_DEPTH  32

`endif

// ### rtl/busr_fifo.v
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module busr_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    clk,
    rstn,
    in_valid,
    in_ready,
    in_data,
    out_valid,
    out_ready,
    out_data
);
    input  wire             clk;
    input  wire             rstn;
    input  wire             in_valid;
    output wire             in_ready;
    input  wire [WIDTH-1:0] in_data;
    output wire             out_valid;
    input  wire             out_ready;
    output wire [WIDTH-1:0] out_data;

    reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr_q;
    reg  [AW-1:0]    rd_ptr_q;
    reg  [AW:0]      count_q;
    reg              ready_q;
    wire             push;
    wire             pop;
    wire [AW:0]      count_d;

    // pointer step with wrap at depth
    function [AW-1:0] ptr_next;
        input [AW-1:0] p;
        begin
            if (p == DEPTH[AW-1:0] - 1'b1 || DEPTH == (1 << AW) && p == {AW{1'b1}}) begin
                ptr_next = {AW{1'b0}};
            end else begin
                ptr_next = p + 1'b1;
            end
        end
    endfunction

    assign push      = in_valid && ready_q;
    assign pop       = out_valid && out_ready;
    assign out_valid = (count_q != {(AW+1){1'b0}});
    assign out_data  = mem_q[rd_ptr_q];
    assign in_ready  = ready_q;
    assign count_d   = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    always @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q  <= {(AW+1){1'b0}};
            ready_q  <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= ptr_next(wr_ptr_q);
            end
            if (pop) begin
                rd_ptr_q <= ptr_next(rd_ptr_q);
            end
            count_q <= count_d;
            ready_q <= (count_d < DEPTH[AW:0]);
        end
    end
endmodule // busr_fifo

// ### rtl/busr_shift_reg.v
// four-bit bidirectional universal shift register fed by a command queue
//
// Operation
// (RL1) four flip-flops hold the state and each drives its own bit of register_out.
// (RL2) mode_select picks hold, shift right, shift left or parallel load for each step.
// (RL3) mode 0 keeps all four bits and ignores the serial and parallel inputs.
// (RL4) mode 2 shifts left: bit n takes old bit n+1 and bit 3 takes left_serial_in.
// (RL5) mode 1 shifts right: bit 0 takes right_serial_in and bit n takes old bit n-1.
// (RL6) mode 3 loads all four parallel_data_in bits together.
// (RL7) async_clear_n low forces register_out to zero at once without a clock.
// (RL8) state changes only on the rising clock edge using values sampled before it; async_clear_n low still clears register_out without an edge.
// (RL9) the feeding logic keeps its inputs stable around each rising edge.
// (RL10) every bit updates on the same edge of the single clock.
// (RL11) after async_clear_n rises, operation resumes at the next edge from zero.
`timescale 1ns/1ps
`include "busr_map.vh"
module busr_shift_reg #(
    parameter DEPTH = `BUSR_QUEUE_DEPTH,
    parameter AW    = 5
) (
    clk,
    rstn,
    async_clear_n,
    cmd_valid,
    cmd_ready,
    mode_select,
    parallel_data_in,
    left_serial_in,
    right_serial_in,
    run,
    step_done,
    register_out
);
    input  wire                   clk;
    input  wire                   rstn;
    input  wire                   async_clear_n;
    input  wire                   cmd_valid;
    output wire                   cmd_ready;
    input  wire [1:0]             mode_select;
    input  wire [`BUSR_WIDTH-1:0] parallel_data_in;
    input  wire                   left_serial_in;
    input  wire                   right_serial_in;
    input  wire                   run;
    output reg                    step_done;
    output reg  [`BUSR_WIDTH-1:0] register_out;

    wire [`BUSR_CMD_WIDTH-1:0] cmd_in;
    wire [`BUSR_CMD_WIDTH-1:0] cmd;
    wire                       cmd_avail;
    wire                       take;
    wire [1:0]                 mode;
    wire [`BUSR_WIDTH-1:0]     pdata;
    wire                       right_in;
    wire                       left_in;
    reg  [`BUSR_WIDTH-1:0]     reg_d;

    // commands are queued with the inputs captured on the accepting edge (see RL9)
    assign cmd_in = {mode_select, right_serial_in, left_serial_in, parallel_data_in};

    busr_fifo #(
        .WIDTH (`BUSR_CMD_WIDTH),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_queue (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (cmd_valid),
        .in_ready  (cmd_ready),
        .in_data   (cmd_in),
        .out_valid (cmd_avail),
        .out_ready (run),
        .out_data  (cmd)
    );

    assign take  = cmd_avail && run;
    assign mode  = cmd[`BUSR_CMD_MODE_MSB:`BUSR_CMD_MODE_LSB];
    assign pdata = cmd[`BUSR_CMD_DATA_MSB:`BUSR_CMD_DATA_LSB];
    assign right_in = cmd[`BUSR_CMD_RIGHT_BIT];
    assign left_in  = cmd[`BUSR_CMD_LEFT_BIT];

    // steering for one stage: the mode picks what feeds the bit
    function bit_next;
        input [1:0] sel;
        input       own;
        input       below;
        input       above;
        input       load;
        begin
            case (sel) // see RL2
                `BUSR_MODE_HOLD: begin
                    bit_next = own; // see RL3
                end
                `BUSR_MODE_RIGHT: begin
                    bit_next = below; // see RL5
                end
                `BUSR_MODE_LEFT: begin
                    bit_next = above; // see RL4
                end
                `BUSR_MODE_LOAD: begin
                    bit_next = load; // see RL6
                end
                default: begin
                    bit_next = own;
                end
            endcase
        end
    endfunction

    // next-state selection, one steering stage per flip-flop
    always @* begin
        reg_d = register_out;
        if (take) begin
            reg_d[0] = bit_next(mode, register_out[0], right_in, register_out[1], pdata[0]);
            reg_d[1] = bit_next(mode, register_out[1], register_out[0],
                                register_out[2], pdata[1]);
            reg_d[2] = bit_next(mode, register_out[2], register_out[1],
                                register_out[3], pdata[2]);
            reg_d[3] = bit_next(mode, register_out[3], register_out[2], left_in, pdata[3]);
        end
    end

    // storage flip-flops, one edge for all bits (see RL1) (see RL8) (see RL10)
    always @(posedge clk or negedge async_clear_n) begin
        if (!async_clear_n) begin
            register_out <= `BUSR_RESET_VALUE; // see RL7
            step_done    <= 1'b0;
        end else if (!rstn) begin
            register_out <= `BUSR_RESET_VALUE;
            step_done    <= 1'b0;
        end else begin
            register_out <= reg_d; // see RL11
            step_done    <= take;
        end
    end
endmodule // busr_shift_reg

// ### testbench/busr_chk_assertions.sv
// port checker for the shift register
`timescale 1ns/1ps
module busr_chk (
    input wire       clk,
    input wire       rstn,
    input wire       async_clear_n,
    input wire       cmd_ready,
    input wire       run,
    input wire       step_done,
    input wire [3:0] register_out
);
    sequence s_clr;
        !async_clear_n;
    endsequence
    property p_clr;
        @(posedge clk) disable iff (!rstn) s_clr |-> register_out == 4'h0 && !step_done;
    endproperty
    a_clr: assert property (p_clr) else $error("not cleared");
    property p_resume;
        @(posedge clk) disable iff (!rstn) s_clr ##1 async_clear_n |-> register_out == 4'h0;
    endproperty
    a_resume: assert property (p_resume) else $error("no zero start");
    property p_edge;
        @(posedge clk) disable iff (!rstn || !async_clear_n)
            $changed(register_out) && $past(rstn) |-> step_done;
    endproperty
    a_edge: assert property (p_edge) else $error("change without step");
    property p_run;
        @(posedge clk) disable iff (!rstn) step_done |-> $past(run);
    endproperty
    a_run: assert property (p_run) else $error("step while stalled");
    property p_rst;
        @(posedge clk) disable iff (!async_clear_n)
            !rstn |=> !cmd_ready && register_out == 4'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    sequence s_release;
        !rstn ##1 rstn;
    endsequence
    property p_ready;
        @(posedge clk) s_release |=> cmd_ready;
    endproperty
    a_ready: assert property (p_ready) else $error("queue not ready after reset");
endmodule // busr_chk
bind busr_shift_reg busr_chk chk (.clk(clk), .rstn(rstn), .async_clear_n(async_clear_n),
    .cmd_ready(cmd_ready), .run(run), .step_done(step_done), .register_out(register_out));

// ### testbench/busr_src.sv
// command source standing for the feeding logic
`timescale 1ns/1ps
module busr_src (
    input  wire       clk,
    input  wire       go,
    input  wire [7:0] cmd,
    input  wire       cmd_ready,
    output reg        cmd_valid,
    output reg  [7:0] cmd_q
);
    initial cmd_valid = 1'b0;
    initial cmd_q = 8'h00;
    always @(posedge clk) begin
        if (go && !cmd_valid) begin
            cmd_valid <= 1'b1;
            cmd_q     <= cmd;
        end else if (cmd_ready) begin
            cmd_valid <= 1'b0;
            cmd_q     <= ~cmd_q;
        end
    end
endmodule // busr_src

// ### testbench/bidir_universal_shift_reg4_tb.sv
// testbench for the shift register
`timescale 1ns/1ps
module bidir_universal_shift_reg4_tb;
    reg        clk = 1'b0, rstn = 1'b0, clr_n = 1'b1, run = 1'b1, go = 1'b0;
    reg  [7:0] cmd = 8'h00;
    wire       vld, rdy, done;
    wire [7:0] f;
    wire [3:0] q;
    integer    mismatches = 0, checks = 0, cyc = 0, i, n;
    reg [11:0] rows [0:6];
    always #2.5 clk = ~clk;
    busr_src src (.clk(clk), .go(go), .cmd(cmd), .cmd_ready(rdy), .cmd_valid(vld), .cmd_q(f));
    busr_shift_reg #(.DEPTH(4), .AW(2)) dut (.clk(clk), .rstn(rstn), .async_clear_n(clr_n),
        .cmd_valid(vld), .cmd_ready(rdy), .mode_select(f[7:6]), .parallel_data_in(f[3:0]),
        .left_serial_in(f[4]), .right_serial_in(f[5]), .run(run), .step_done(done),
        .register_out(q));
    task test_done;
        begin
            $display("checks %0d mismatches %0d", checks, mismatches);
            if (mismatches == 0 && checks > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    task cmp(input [3:0] got, input [3:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("[ERR] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task cmp_flag(input got, input exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("[ERR] %0t flag %b expected %b", $time, got, exp);
            end
        end
    endtask
    task cmp_count(input integer got, input integer exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
            end
        end
    endtask
    task push(input [7:0] c);
        begin
            @(posedge clk);
            cmd <= c;
            go  <= 1'b1;
            @(posedge clk);
            go  <= 1'b0;
            n = 0;
            #1;
            while (vld !== 1'b0 && n < 8) begin
                @(posedge clk);
                #1;
                n = n + 1;
            end
        end
    endtask
    task step(input [11:0] r);
        begin
            push(r[11:4]);
            n = 0;
            while (done !== 1'b1 && n < 8) begin
                @(posedge clk);
                #1;
                n = n + 1;
            end
            cmp_flag(done, 1'b1);
            cmp(q, r[3:0]);
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            mismatches = mismatches + 1;
            test_done;
        end
    end
    initial begin
        rows[0] = 12'hCAA; rows[1] = 12'h605; rows[2] = 12'h90A; rows[3] = 12'h3FA;
        rows[4] = 12'h805; rows[5] = 12'h40A; rows[6] = 12'hC33;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        #1;
        cmp(q, 4'h0);
        cmp_flag(rdy, 1'b0);
        cmp_flag(done, 1'b0);
        $display("reset done");
        for (i = 0; i < 7; i = i + 1) step(rows[i]);
        $display("mode rows done");
        @(posedge clk);
        run <= 1'b0;
        for (i = 1; i < 6; i = i + 1) push(8'hC0 | i[7:0]);
        cmp_flag(rdy, 1'b0);
        cmp_flag(vld, 1'b1);
        @(posedge clk);
        run <= 1'b1;
        n = 0;
        for (i = 0; i < 12; i = i + 1) begin
            @(posedge clk);
            #1;
            if (done === 1'b1) n = n + 1;
        end
        cmp_count(n, 5);
        cmp(q, 4'h5);
        $display("queue fill done");
        @(posedge clk);
        clr_n <= 1'b0;
        #1;
        cmp(q, 4'h0);
        @(posedge clk);
        clr_n <= 1'b1;
        step(12'h601);
        $display("clear done");
        step(12'hCFF);
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        #1;
        cmp(q, 4'h0);
        cmp_flag(rdy, 1'b0);
        step(12'h908);
        $display("mid-run reset done");
        test_done;
    end
endmodule // bidir_universal_shift_reg4_tb
